// >>> rtl/evb_defines.svh
`ifndef EVB_DEFINES_SVH
`define EVB_DEFINES_SVH

// Register byte offsets
`define EVB_A_CTRL       8'h00
`define EVB_A_NEGO_REQ   8'h04
`define EVB_A_NEGO_RESP  8'h08
`define EVB_A_NEGO_SIZE  8'h0c
`define EVB_A_TERM_LIM   8'h10
`define EVB_A_EVT_ID     8'h14
`define EVB_A_EVT_STATE  8'h18
`define EVB_A_READ_LO    8'h1c
`define EVB_A_READ_HI    8'h20
`define EVB_A_STATUS     8'h24
`define EVB_A_MASK       8'h28
`define EVB_A_TX_STAT    8'h2c

// Control bits
`define EVB_CTRL_START   0
`define EVB_CTRL_PUNK    1

// Status bits
`define EVB_ST_NEGO_OK   0
`define EVB_ST_NEGO_BAD  1
`define EVB_ST_SENT      2
`define EVB_ST_POLL      3
`define EVB_ST_BAD_EVT   4
`define EVB_ST_W         5

// Sizes and result codes
`define EVB_DEF_BUF      16'h0100
`define EVB_MIN_BUF      16'h0100
`define EVB_RC_OK        8'h00
`define EVB_RC_BAD_SIZE  8'h80
`define EVB_RC_UNSUP     8'h05
`define EVB_MAX_MEMBER   8'h07

`endif

// >>> rtl/evb_pkg.sv
package evb_pkg;

  typedef enum logic [1:0] {
    EVB_IDLE  = 2'b00,
    EVB_CHECK = 2'b01,
    EVB_SEND  = 2'b11,
    EVB_DONE  = 2'b10
  } evb_state_t;

  typedef enum logic [7:0] {  // RL17
    EVB_CAT_OP   = 8'h00,
    EVB_CAT_DISC = 8'h01,
    EVB_CAT_NUM  = 8'h02
  } evb_cat_t;

  // Bytes of the reading for a width code
  function automatic logic [3:0] evb_reading_bytes(input logic [2:0] w);
    return 4'h1 << w[2:1];
  endfunction : evb_reading_bytes

  // Payload bytes for a category
  function automatic logic [4:0] evb_payload_len(input logic [7:0] cat,
                                                 input logic [2:0] w);
    case (cat)
      EVB_CAT_DISC: return 5'h06;
      EVB_CAT_NUM:  return 5'h06 + {1'b0, evb_reading_bytes(w)};
      default:      return 5'h05;
    endcase
  endfunction : evb_payload_len

endpackage : evb_pkg

// >>> rtl/evb_fmt.sv
`timescale 1ns/1ps
`default_nettype none
module evb_fmt
  import evb_pkg::*;
(
  // Event fields
  input  wire logic [15:0] sensor_identifier,
  input  wire logic [7:0]  sensor_event_category,
  input  wire logic [7:0]  composite_member_index,
  input  wire logic [7:0]  current_event_state,
  input  wire logic [7:0]  prior_event_state,
  input  wire logic [2:0]  reading_width_code,
  input  wire logic [63:0] current_reading,
  // Byte select
  input  wire logic [4:0]  idx,
  output logic      [7:0]  byte_out,
  output logic             byte_last
);

  logic [4:0] len;
  logic [2:0] rsel;

  always_comb
  begin
    len       = evb_payload_len(sensor_event_category, reading_width_code);
    rsel      = 3'(idx - 5'h06);
    byte_last = (idx == 5'(len - 5'h01));
    case (idx)
      5'h00: byte_out = sensor_identifier[7:0];   // RL10
      5'h01: byte_out = sensor_identifier[15:8];  // RL10
      5'h02: byte_out = sensor_event_category;    // RL11
      5'h03:
        byte_out = (sensor_event_category == EVB_CAT_DISC) ?
                   composite_member_index : current_event_state;  // RL12
      5'h04:
        byte_out = (sensor_event_category == EVB_CAT_DISC) ?
                   current_event_state : prior_event_state;  // RL13
      5'h05:
        byte_out = (sensor_event_category == EVB_CAT_NUM) ?
                   {5'h00, reading_width_code} : prior_event_state;  // RL16
      default: byte_out = current_reading[{rsel, 3'b000} +: 8];  // RL16
    endcase
  end

endmodule : evb_fmt
`default_nettype wire

// >>> rtl/evb_irq.sv
`timescale 1ns/1ps
`default_nettype none
module evb_irq
  import evb_pkg::*;
#(
  parameter int W = 5
)
(
  // Clock and reset
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic         ce,
  // Events and software access
  input  wire logic [W-1:0] set,
  input  wire logic         rd_clear,
  input  wire logic         mask_we,
  input  wire logic [W-1:0] mask_wdata,
  output logic      [W-1:0] status_ff,
  output logic      [W-1:0] mask_ff,
  output logic              irq_ff
);

  // Sticky status, set wins over read clear
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      status_ff <= '0;
    else if (ce)
      status_ff <= (rd_clear ? '0 : status_ff) | set;

  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      mask_ff <= '0;
    else if (ce && mask_we)
      mask_ff <= mask_wdata;

  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      irq_ff <= 1'b0;
    else if (ce)
      irq_ff <= |(((rd_clear ? '0 : status_ff) | set) & mask_ff);

endmodule : evb_irq
`default_nettype wire

// >>> rtl/evb_top.sv
// Behaviour
// RL1: Negotiated size is the smaller of receiver and terminus limits.
// RL2: Receiver fetches oversized events with the polled fetch command.
// RL3: Oversized event raises a poll-needed notice instead of being sent.
// RL4: Without negotiation the buffer size is 256 bytes.
// RL5: Receiver limit below 256 answers with result code 0x80.
// RL6: Receiver limit is 16 bits, header plus payload only.
// RL7: Answer is 8-bit result code then 16-bit terminus limit.
// RL8: Negotiated size applies to every event, asynchronous or polled.
// RL9: No limit below 256 may be advertised by either side.
// RL10: Event data opens with the 16-bit sensor identifier.
// RL11: An 8-bit event category follows the identifier.
// RL12: Discrete events carry member index limited to 0 through 7.
// RL13: Discrete events then carry the current event state.
// RL14: Negotiation support is optional, recommended with receiver setup.
// RL15: Prior state follows; repeats current state when unknown.
// RL16: Numeric events carry width code then reading in that width.
// RL17: Categories are 0 operational, 1 discrete, 2 numeric.
`timescale 1ns/1ps
`default_nettype none
`include "evb_defines.svh"
module evb_top
  import evb_pkg::*;
#(
  parameter logic        NEGO_SUPPORTED = 1'b1,
  parameter logic [15:0] TERM_LIMIT_RST = 16'h0400,
  parameter logic [15:0] HDR_BYTES      = 16'h0010
)
(
  // Clock, reset, enable
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        ce,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic      [31:0] prdata,
  output logic             pslverr,
  // Event byte stream
  output logic             tx_valid,
  output logic      [7:0]  tx_data,
  output logic             tx_last,
  input  wire logic        tx_ready,
  // Notices
  output logic             poll_needed_notice,
  output logic             irq
);

  logic             pready_ff;
  logic [31:0]      prdata_ff;
  logic             pslverr_ff;
  logic             tx_valid_ff;
  logic [7:0]       tx_data_ff;
  logic             tx_last_ff;
  logic             poll_ff;
  logic             irq_ff;
  evb_state_t       state_ff;
  logic [4:0]       idx_ff;
  logic             punk_ff;
  logic [15:0]      term_limit_ff;
  logic [15:0]      nego_size_ff;
  logic             nego_done_ff;
  logic [7:0]       result_code_ff;
  logic [15:0]      id_ff;
  logic [7:0]       cat_ff;
  logic [7:0]       member_ff;
  logic [7:0]       cur_ff;
  logic [7:0]       prior_ff;
  logic [2:0]       wcode_ff;
  logic [63:0]      reading_ff;
  logic [`EVB_ST_W-1:0] status;
  logic [`EVB_ST_W-1:0] mask;
  logic [`EVB_ST_W-1:0] ev_set;
  logic             wr_en;
  logic             rd_en;
  logic             setup;
  logic             busy;
  logic             start;
  logic [15:0]      req_lim;
  logic [15:0]      total_len;
  logic             oversize;
  logic             bad_evt;
  logic [7:0]       prior_eff;
  logic [7:0]       fmt_byte;
  logic             fmt_last;
  logic             load;
  logic             mapped;
  logic [31:0]      rd_mux;

  assign pready             = pready_ff;
  assign prdata             = prdata_ff;
  assign pslverr            = pslverr_ff;
  assign tx_valid           = tx_valid_ff;
  assign tx_data            = tx_data_ff;
  assign tx_last            = tx_last_ff;
  assign poll_needed_notice = poll_ff;
  assign irq                = irq_ff;

  // Bus decode
  assign setup   = psel && !penable;
  assign wr_en   = ce && psel && penable && pready_ff && pwrite;
  assign rd_en   = ce && psel && penable && pready_ff && !pwrite;
  assign busy    = (state_ff != EVB_IDLE);
  assign start   = wr_en && (paddr == `EVB_A_CTRL) &&
                   pwdata[`EVB_CTRL_START] && !busy;
  assign req_lim = pwdata[15:0];  // RL6

  always_comb
  begin
    mapped = 1'b1;
    rd_mux = 32'h0;
    case (paddr)
      `EVB_A_CTRL:      rd_mux = {30'h0, punk_ff, 1'b0};
      `EVB_A_NEGO_REQ:  rd_mux = 32'h0;
      `EVB_A_NEGO_RESP: rd_mux = {8'h0, term_limit_ff, result_code_ff};
      `EVB_A_NEGO_SIZE: rd_mux = {15'h0, nego_done_ff, nego_size_ff};
      `EVB_A_TERM_LIM:  rd_mux = {16'h0, term_limit_ff};
      `EVB_A_EVT_ID:    rd_mux = {member_ff, cat_ff, id_ff};
      `EVB_A_EVT_STATE: rd_mux = {13'h0, wcode_ff, prior_ff, cur_ff};
      `EVB_A_READ_LO:   rd_mux = reading_ff[31:0];
      `EVB_A_READ_HI:   rd_mux = reading_ff[63:32];
      `EVB_A_STATUS:    rd_mux = {27'h0, status};
      `EVB_A_MASK:      rd_mux = {27'h0, mask};
      `EVB_A_TX_STAT:   rd_mux = {31'h0, busy};
      default:          mapped = 1'b0;
    endcase
  end

  // APB answer, one access cycle
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      pready_ff  <= 1'b0;
      prdata_ff  <= 32'h0;
      pslverr_ff <= 1'b0;
    end
    else if (ce)
    begin
      pready_ff  <= setup;
      prdata_ff  <= (setup && !pwrite) ? rd_mux : 32'h0;
      pslverr_ff <= setup && !mapped;
    end
  // Terminus limit, never below the minimum
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      term_limit_ff <= TERM_LIMIT_RST;
    else if (wr_en && paddr == `EVB_A_TERM_LIM)
      term_limit_ff <= (pwdata[15:0] < `EVB_MIN_BUF) ?
                       `EVB_MIN_BUF : pwdata[15:0];  // RL9
  // Size negotiation command
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      nego_size_ff   <= `EVB_DEF_BUF;  // RL4
      nego_done_ff   <= 1'b0;
      result_code_ff <= `EVB_RC_OK;
    end
    else if (wr_en && paddr == `EVB_A_NEGO_REQ)
    begin
      if (!NEGO_SUPPORTED)
        result_code_ff <= `EVB_RC_UNSUP;  // RL14
      else if (req_lim < `EVB_MIN_BUF)
        result_code_ff <= `EVB_RC_BAD_SIZE;  // RL5
      else
      begin
        result_code_ff <= `EVB_RC_OK;  // RL7
        nego_done_ff   <= 1'b1;
        nego_size_ff   <= (req_lim < term_limit_ff) ?
                          req_lim : term_limit_ff;  // RL1
      end
    end
  // Event field registers, locked while busy
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      punk_ff    <= 1'b0;
      id_ff      <= 16'h0;
      cat_ff     <= 8'h0;
      member_ff  <= 8'h0;
      cur_ff     <= 8'h0;
      prior_ff   <= 8'h0;
      wcode_ff   <= 3'h0;
      reading_ff <= 64'h0;
    end
    else if (wr_en && !busy)
    begin
      case (paddr)
        `EVB_A_CTRL:      punk_ff <= pwdata[`EVB_CTRL_PUNK];
        `EVB_A_EVT_ID:
        begin
          id_ff     <= pwdata[15:0];
          cat_ff    <= pwdata[23:16];
          member_ff <= pwdata[31:24];
        end
        `EVB_A_EVT_STATE:
        begin
          cur_ff   <= pwdata[7:0];
          prior_ff <= pwdata[15:8];
          wcode_ff <= pwdata[18:16];
        end
        `EVB_A_READ_LO:   reading_ff[31:0] <= pwdata;
        `EVB_A_READ_HI:   reading_ff[63:32] <= pwdata;
        default:          punk_ff <= punk_ff;
      endcase
    end
  // Event checks
  assign prior_eff = punk_ff ? cur_ff : prior_ff;  // RL15
  assign total_len = HDR_BYTES + {11'h0, evb_payload_len(cat_ff, wcode_ff)};
  assign oversize  = total_len > nego_size_ff;  // RL8
  assign bad_evt   = (cat_ff > EVB_CAT_NUM) ||
                     (cat_ff == EVB_CAT_DISC &&
                      member_ff > `EVB_MAX_MEMBER);  // RL12
  assign load      = (state_ff == EVB_SEND) && (!tx_valid_ff || tx_ready);

  evb_fmt u_fmt (
    .sensor_identifier      (id_ff),
    .sensor_event_category  (cat_ff),
    .composite_member_index (member_ff),
    .current_event_state    (cur_ff),
    .prior_event_state      (prior_eff),
    .reading_width_code     (wcode_ff),
    .current_reading        (reading_ff),
    .idx                    (idx_ff),
    .byte_out               (fmt_byte),
    .byte_last              (fmt_last)
  );
  // Transmit sequencer
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      state_ff <= EVB_IDLE;
      idx_ff   <= 5'h0;
    end
    else if (ce)
    begin
      case (state_ff)
        EVB_IDLE:
          if (start)
            state_ff <= EVB_CHECK;
        EVB_CHECK:
        begin
          idx_ff   <= 5'h0;
          state_ff <= (bad_evt || oversize) ? EVB_IDLE : EVB_SEND;  // RL3
        end
        EVB_SEND:
          if (load)
          begin
            idx_ff <= idx_ff + 5'h01;
            if (fmt_last)
              state_ff <= EVB_DONE;
          end
        EVB_DONE:
          if (tx_ready)
            state_ff <= EVB_IDLE;
        default:   state_ff <= EVB_IDLE;
      endcase
    end
  // Stream output
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      tx_valid_ff <= 1'b0;
      tx_data_ff  <= 8'h0;
      tx_last_ff  <= 1'b0;
    end
    else if (ce)
    begin
      if (load)
      begin
        tx_valid_ff <= 1'b1;
        tx_data_ff  <= fmt_byte;
        tx_last_ff  <= fmt_last;
      end
      else if (state_ff == EVB_DONE && tx_ready)
      begin
        tx_valid_ff <= 1'b0;
        tx_last_ff  <= 1'b0;
      end
    end
  // Poll-needed notice for the receiver to fetch by polling
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      poll_ff <= 1'b0;
    else if (ce)
      poll_ff <= (state_ff == EVB_CHECK) && !bad_evt && oversize;  // RL3 RL2
  // Interrupt sources
  always_comb
  begin
    ev_set = '0;
    ev_set[`EVB_ST_NEGO_OK]  = wr_en && paddr == `EVB_A_NEGO_REQ &&
                               NEGO_SUPPORTED && req_lim >= `EVB_MIN_BUF;
    ev_set[`EVB_ST_NEGO_BAD] = wr_en && paddr == `EVB_A_NEGO_REQ &&
                               (!NEGO_SUPPORTED || req_lim < `EVB_MIN_BUF);
    ev_set[`EVB_ST_SENT]     = ce && state_ff == EVB_DONE && tx_ready;
    ev_set[`EVB_ST_POLL]     = ce && state_ff == EVB_CHECK && !bad_evt &&
                               oversize;
    ev_set[`EVB_ST_BAD_EVT]  = ce && state_ff == EVB_CHECK && bad_evt;
  end

  evb_irq #(.W (`EVB_ST_W)) u_irq (
    .pclk       (pclk),
    .presetn    (presetn),
    .ce         (ce),
    .set        (ev_set),
    .rd_clear   (rd_en && paddr == `EVB_A_STATUS),
    .mask_we    (wr_en && paddr == `EVB_A_MASK),
    .mask_wdata (pwdata[`EVB_ST_W-1:0]),
    .status_ff  (status),
    .mask_ff    (mask),
    .irq_ff     (irq_ff)
  );

  // Checks
  sequence s_nego_wr;
    wr_en && paddr == `EVB_A_NEGO_REQ && NEGO_SUPPORTED;
  endsequence
  sequence s_check_ok;
    ce && state_ff == EVB_CHECK && !bad_evt;
  endsequence
  a_bad_size_code: assert property (  // RL5
    @(posedge pclk) disable iff (!presetn)
    s_nego_wr and (req_lim < `EVB_MIN_BUF) |=>
      result_code_ff == `EVB_RC_BAD_SIZE && $stable(nego_size_ff))
    else $error("short receiver limit not refused");
  a_nego_min_size: assert property (  // RL1
    @(posedge pclk) disable iff (!presetn)
    s_nego_wr and (req_lim >= `EVB_MIN_BUF) |=>
      nego_size_ff == (($past(req_lim) < term_limit_ff) ?
                       $past(req_lim) : term_limit_ff))
    else $error("negotiated size is not the smaller limit");
  a_default_size: assert property (  // RL4
    @(posedge pclk) disable iff (!presetn)
    !nego_done_ff |-> nego_size_ff == `EVB_DEF_BUF)
    else $error("default buffer size lost");
  a_term_limit_min: assert property (  // RL9
    @(posedge pclk) disable iff (!presetn)
    term_limit_ff >= `EVB_MIN_BUF && nego_size_ff >= `EVB_MIN_BUF)
    else $error("limit below minimum");
  a_poll_oversize: assert property (  // RL3
    @(posedge pclk) disable iff (!presetn)
    s_check_ok and oversize |=> poll_needed_notice && state_ff == EVB_IDLE
      ##1 !poll_needed_notice || !$past(ce))
    else $error("oversized event not turned into notice");
  a_send_fits: assert property (  // RL8
    @(posedge pclk) disable iff (!presetn)
    $rose(tx_valid_ff) |-> !oversize && !poll_needed_notice)
    else $error("oversized event streamed");
  a_id_first: assert property (  // RL10
    @(posedge pclk) disable iff (!presetn)
    $rose(tx_valid_ff) |-> tx_data_ff == id_ff[7:0])
    else $error("payload does not open with identifier");
  a_member_range: assert property (  // RL12
    @(posedge pclk) disable iff (!presetn)
    state_ff == EVB_SEND && cat_ff == EVB_CAT_DISC |->
      member_ff <= `EVB_MAX_MEMBER)
    else $error("member index out of range sent");

endmodule : evb_top
`default_nettype wire

// >>> tb/evb_sink.sv
`timescale 1ns/1ps
`default_nettype none
module evb_sink
(
  // Clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // Byte stream from the terminus
  input  wire logic       tx_valid,
  input  wire logic [7:0] tx_data,
  input  wire logic       tx_last,
  output logic            tx_ready,
  // Notices and pacing
  input  wire logic       poll_needed_notice,
  input  wire logic       slow,
  output logic      [7:0] rx_cnt_ff,
  output logic      [7:0] poll_cnt_ff,
  output logic      [7:0] last_cnt_ff
);
  logic [7:0] mem_ff [0:255];
  logic       tog_ff;

  // Stall every other cycle when slow
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      tog_ff <= 1'b0;
    else
      tog_ff <= ~tog_ff;
  end

  assign tx_ready = !slow || tog_ff;

  // Capture accepted bytes
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rx_cnt_ff   <= 8'h00;
      last_cnt_ff <= 8'h00;
    end
    else if (tx_valid && tx_ready)
    begin
      mem_ff[rx_cnt_ff] <= tx_data;
      rx_cnt_ff         <= rx_cnt_ff + 8'h01;
      last_cnt_ff       <= last_cnt_ff + {7'h00, tx_last};
    end
  end

  // Oversized event pending a polled fetch
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      poll_cnt_ff <= 8'h00;
    else if (poll_needed_notice)
      poll_cnt_ff <= poll_cnt_ff + 8'h01;
  end
endmodule : evb_sink
`default_nettype wire

// >>> tb/evb_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "evb_defines.svh"
module evb_top_tb;
  localparam logic [63:0] RDG = 64'h8877665544332211;
  logic        pclk;
  logic        presetn;
  logic        ce;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic        pready;
  logic [31:0] prdata;
  logic        pslverr;
  logic        tx_valid;
  logic [7:0]  tx_data;
  logic        tx_last;
  logic        tx_ready;
  logic        poll_needed_notice;
  logic        irq;
  logic        slow;
  logic [7:0]  rx_cnt;
  logic [7:0]  poll_cnt;
  logic [7:0]  last_cnt;
  logic [7:0]  b_rx;
  logic [7:0]  b_last;
  logic [7:0]  b_poll;
  logic [31:0] rdata;
  logic        rerr;
  logic [7:0]  exq[$];
  int          errors;
  int          cmp_count;
  int          cycles;

  evb_top #(.HDR_BYTES(16'h00fa)) DUT (
    .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .tx_valid(tx_valid), .tx_data(tx_data), .tx_last(tx_last),
    .tx_ready(tx_ready), .poll_needed_notice(poll_needed_notice),
    .irq(irq));

  evb_sink sink (
    .pclk(pclk), .presetn(presetn), .tx_valid(tx_valid),
    .tx_data(tx_data), .tx_last(tx_last), .tx_ready(tx_ready),
    .poll_needed_notice(poll_needed_notice), .slow(slow),
    .rx_cnt_ff(rx_cnt), .poll_cnt_ff(poll_cnt), .last_cnt_ff(last_cnt));

  always #10 pclk = ~pclk;

  task automatic final_report;
    if (errors == 0 && cmp_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : final_report

  always @(posedge pclk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      errors++;
      final_report;
    end
  end

  task automatic check(input logic [63:0] got, input logic [63:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
    end
    while (pready !== 1'b1);
    rdata = prdata;
    rerr  = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    check(rdata, exp);
  endtask : rdchk

  // Load fields, start, wait until idle
  task automatic run_evt(input logic [31:0] id, input logic [31:0] st,
                         input logic [31:0] ctrl, input logic hold = 1'b0);
    int n;
    b_rx   = rx_cnt;
    b_last = last_cnt;
    b_poll = poll_cnt;
    apb(1'b1, `EVB_A_EVT_ID, id);
    apb(1'b1, `EVB_A_EVT_STATE, st);
    apb(1'b1, `EVB_A_CTRL, ctrl);
    if (hold)
    begin
      ce <= 1'b0;
      repeat (6) @(posedge pclk);
      check({tx_valid, rx_cnt, poll_needed_notice}, {1'b0, b_rx, 1'b0});
      ce <= 1'b1;
    end
    n = 0;
    do
    begin
      apb(1'b0, `EVB_A_TX_STAT, 32'h0000_0000);
      n++;
    end
    while (rdata[0] !== 1'b0 && n < 100);
    check(n < 100, 1'b1);
  endtask : run_evt

  task automatic chk_stream;
    check(8'(rx_cnt - b_rx), exq.size());
    check(8'(last_cnt - b_last), exq.size() > 0);
    foreach (exq[i])
      check(sink.mem_ff[8'(b_rx + i)], exq[i]);
  endtask : chk_stream

  initial
  begin
    pclk    = 1'b0;
    presetn = 1'b0;
    ce      = 1'b1;
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 8'h00;
    pwdata  = 32'h0000_0000;
    slow    = 1'b1;
    errors  = 0;
    cmp_count = 0;
    cycles  = 0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    rdchk(`EVB_A_NEGO_SIZE, 32'h0000_0100);
    rdchk(`EVB_A_TERM_LIM, 32'h0000_0400);
    rdchk(`EVB_A_MASK, 32'h0000_0000);
    apb(1'b0, 8'h30, 32'h0000_0000);
    check({rerr, rdata}, {1'b1, 32'h0000_0000});
    // Default size holds exactly 256 bytes
    exq = '{8'h34, 8'h12, 8'h01, 8'h03, 8'h05, 8'h02};
    run_evt(32'h0301_1234, 32'h0000_0205, 32'h1, 1'b1);
    chk_stream;
    rdchk(`EVB_A_STATUS, 32'h0000_0004);
    rdchk(`EVB_A_STATUS, 32'h0000_0000);
    // Refused negotiation raises irq
    apb(1'b1, `EVB_A_MASK, 32'h0000_001f);
    rdchk(`EVB_A_MASK, 32'h0000_001f);
    apb(1'b1, `EVB_A_NEGO_REQ, 32'h0000_00ff);
    rdchk(`EVB_A_NEGO_RESP, 32'h0004_0080);
    check(irq, 1'b1);
    rdchk(`EVB_A_STATUS, 32'h0000_0002);
    rdchk(`EVB_A_NEGO_SIZE, 32'h0000_0100);
    check(irq, 1'b0);
    // Accepted limits take the smaller one
    for (int k = 0; k < 3; k++)
    begin
      apb(1'b1, `EVB_A_NEGO_REQ,
          k == 0 ? 32'h100 : k == 1 ? 32'h300 : 32'h800);
      rdchk(`EVB_A_NEGO_RESP, 32'h0004_0000);
      rdchk(`EVB_A_NEGO_SIZE, k == 0 ? 32'h10100 : k == 1 ? 32'h10300
                                                          : 32'h10400);
    end
    // Operational category, prior unknown
    exq = '{8'hcd, 8'hab, 8'h00, 8'h07, 8'h07};
    run_evt(32'h0000_abcd, 32'h0000_0907, 32'h3);
    chk_stream;
    apb(1'b1, `EVB_A_READ_LO, RDG[31:0]);
    apb(1'b1, `EVB_A_READ_HI, RDG[63:32]);
    for (int w = 0; w < 8; w++)
    begin
      slow <= w[0];
      exq = '{8'h3c, 8'h5a, 8'h02, 8'h06, 8'h02, 8'(w)};
      for (int k = 0; k < (1 << (w >> 1)); k++)
        exq.push_back(RDG[8*k +: 8]);
      run_evt(32'h0002_5a3c, 32'h0000_0206 | 32'(w << 16), 32'h1);
      chk_stream;
    end
    rdchk(`EVB_A_STATUS, 32'h0000_0005);
    // Out of range member and category
    exq.delete();
    run_evt(32'h0801_0001, 32'h0000_0101, 32'h1);
    chk_stream;
    rdchk(`EVB_A_STATUS, 32'h0000_0010);
    run_evt(32'h0003_0001, 32'h0000_0101, 32'h1);
    chk_stream;
    rdchk(`EVB_A_STATUS, 32'h0000_0010);
    // Oversize by one byte goes to polling
    apb(1'b1, `EVB_A_TERM_LIM, 32'h0000_0050);
    rdchk(`EVB_A_TERM_LIM, 32'h0000_0100);
    apb(1'b1, `EVB_A_NEGO_REQ, 32'h0000_0200);
    rdchk(`EVB_A_NEGO_SIZE, 32'h0001_0100);
    rdchk(`EVB_A_STATUS, 32'h0000_0001);
    run_evt(32'h0002_5a3c, 32'h0000_0206, 32'h1);
    chk_stream;
    check(8'(poll_cnt - b_poll), 8'h01);
    rdchk(`EVB_A_STATUS, 32'h0000_0008);
    final_report;
  end
endmodule : evb_top_tb
`default_nettype wire
